// [bench/fsl_host_model.sv]
/*
  apb host model that issues single transfers for the bench.
  assumes one core clock; the slave answers with pready.
*/
`timescale 1ns/1ps
module fsl_host_model (
  input wire logic i_core_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
  end

  // request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er, output logic to);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    rd = i_prdata;
    er = i_pslverr;
    to = (i_pready !== 1'b1);
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : fsl_host_model

// [bench/fsl_sector_lock_properties.sv]
/*
  port checks for the sector lock block.
  assumes the one wait state apb answer of the block.
*/
`timescale 1ns/1ps
module fsl_sector_lock_properties
  import fsl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_accelerate_protect_input,
  input wire logic i_embedded_busy,
  input wire logic i_op_suspended,
  input wire logic i_alternate_overlay_space_active,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_secure_mode
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_ready_one_wait: assert property (i_psel && i_penable && !o_pready && !$past(i_penable) |=> o_pready)
    else $error("pready late");
  a_ready_one_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr alone");
  a_strobe_err: assert property (i_psel && i_penable && i_pwrite && i_pstrb != 4'hf && !o_pready
    |=> o_pready && o_pslverr) else $error("partial strobe taken");
  a_unmapped_err: assert property (i_psel && i_penable && !o_pready && i_paddr > REG_LOCK_WORD
    |=> o_pslverr) else $error("unmapped taken");
  a_write_rdata_zero: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
    else $error("write returned data");
  a_entry_cause: assert property ($rose(o_secure_mode) |-> $past(o_pready && i_pwrite &&
    i_paddr == REG_CMD_DATA && i_pwdata[15:0] == CMD_SEC_ENTER)) else $error("entry without command");
  a_secure_hold: assert property (o_secure_mode && !(o_pready && i_pwrite) |=> o_secure_mode)
    else $error("secure mode dropped");
  a_exit_cause: assert property ($fell(o_secure_mode) |-> $past(o_pready && i_pwrite &&
    i_pwdata[15:0] == CMD_EXIT)) else $error("exit without command");

  c_entry: cover property ($rose(o_secure_mode));
  c_error: cover property (o_pslverr);
  c_exit: cover property ($fell(o_secure_mode));
endmodule : fsl_sector_lock_properties

bind fsl_sector_lock fsl_sector_lock_properties u_props (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .i_accelerate_protect_input(i_accelerate_protect_input), .i_embedded_busy(i_embedded_busy),
  .i_op_suspended(i_op_suspended), .i_alternate_overlay_space_active(i_alternate_overlay_space_active),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_secure_mode(o_secure_mode)
);

// [bench/fsl_sector_lock_test.sv]
/*
  self-checking bench for the sector lock block.
  assumes the host model drives apb; status pins come from here.
*/
`timescale 1ns/1ps
module fsl_sector_lock_test;
  import fsl_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] x;
    logic e;
  } fsl_row_t;
  localparam logic [24:0] SA = 25'h030000;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic acc = 1'b1;
  logic [2:0] blk = 3'b000;
  logic psel, penable, pwrite, pready, pslverr, sec_mode, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int fail_count = 0;
  int checks = 0;
  fsl_row_t rows [6] = '{
    '{1'b0, REG_STATUS, 32'h0, 4'hf, 32'h0, 1'b0},
    '{1'b0, REG_LOCK_WORD, 32'h0, 4'hf, 32'h0000fffd, 1'b0},
    '{1'b0, 8'h24, 32'h0, 4'hf, 32'h0, 1'b1},
    '{1'b1, REG_CMD_ADDR, 32'h00012345, 4'h3, 32'h0, 1'b1},
    '{1'b1, REG_CMD_ADDR, 32'h00012345, 4'hf, 32'h0, 1'b0},
    '{1'b0, REG_CMD_ADDR, 32'h0, 4'hf, 32'h00012345, 1'b0}};

  always #4 i_core_clk = ~i_core_clk;

  fsl_sector_lock uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_accelerate_protect_input(acc),
    .i_embedded_busy(blk[0]), .i_op_suspended(blk[1]), .i_alternate_overlay_space_active(blk[2]),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_secure_mode(sec_mode));
  fsl_host_model host (.i_core_clk(i_core_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));

  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask : cmp1
  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic to;
    host.xfer(w, a, d, s, rd, er, to);
    if (to) begin
      fail_count++;
      results();
    end
  endtask : io
  task automatic rdreg(input logic [7:0] a, input logic [31:0] x);
    io(1'b0, a, 32'h0);
    cmp32(rd, x);
  endtask : rdreg
  task automatic cmd(input logic [24:0] a, input logic [15:0] d);
    io(1'b1, REG_CMD_ADDR, {7'h0, a});
    io(1'b1, REG_CMD_DATA, {16'h0, d});
  endtask : cmd
  task automatic st(input logic [31:0] m, input logic [31:0] x);
    io(1'b0, REG_STATUS, 32'h0);
    cmp32(rd & m, x);
  endtask : st
  task automatic deny(input logic [24:0] a, input logic x);
    io(1'b1, REG_CMD_ADDR, {7'h0, a});
    io(1'b1, REG_OP_CHECK, 32'h0);
    st(32'h20, {26'h0, x, 5'h0});
  endtask : deny
  task automatic lk(input logic [24:0] a, input logic [15:0] c);
    cmd(25'h555, CMD_LOCK_SETUP);
    cmd(25'h2aa, CMD_LOCK_SETUP);
    cmd(a, c);
  endtask : lk
  task automatic range(input logic [24:0] lo, input logic [24:0] hi);
    lk(lo, CMD_RANGE_LOAD);
    cmd(hi, CMD_RANGE_LOAD);
  endtask : range
  task automatic prog(input logic [7:0] o, input logic [15:0] d);
    cmd(SA | 25'h555, CMD_PROG_SETUP);
    cmd(SA | 25'h2aa, 16'h0000);
    cmd(SA | {17'h0, o}, d);
    cmd(SA, CMD_PROG_COMMIT);
  endtask : prog
  task automatic sec(input logic x);
    @(posedge i_core_clk);
    cmp1(sec_mode, x);
  endtask : sec
  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
  endtask : do_reset

  initial begin
    do_reset();
    foreach (rows[i]) begin
      io(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      cmp32(rd, rows[i].x);
      cmp1(er, rows[i].e);
    end
    deny(25'h050000, 1'b0);
    cmd(25'h555, CMD_LOCK_SETUP);
    cmd(25'h2aa, 16'h0099);
    cmd(25'h050000, CMD_LOCK_SETUP);
    deny(25'h050000, 1'b0);
    lk(25'h050000, CMD_LOCK_SETUP);
    deny(25'h050000, 1'b1);
    lk(25'h010040, CMD_LOCK_SETUP);
    deny(25'h010000, 1'b0);
    deny(25'h020000, 1'b1);
    range(25'h020000, 25'h010000);
    st(32'h3, 32'h0);
    range(25'h004000, 25'h020000);
    st(32'h13, 32'h3);
    rdreg(REG_RANGE, 32'h00020000);
    deny(25'h010000, 1'b1);
    lk(25'h00c040, CMD_LOCK_SETUP);
    deny(25'h00c000, 1'b1);
    lk(25'h020040, CMD_LOCK_SETUP);
    deny(25'h020000, 1'b1);
    lk(25'h030040, CMD_LOCK_SETUP);
    deny(25'h030000, 1'b0);
    rdreg(REG_UNLOCK, 32'h0000000c);
    range(25'h050000, 25'h050000);
    rdreg(REG_RANGE, 32'h00020000);
    cmd(SA | 25'h555, CMD_SEC_ENTER);
    sec(1'b1);
    prog(8'h80, 16'h1234);
    st(32'h40, 32'h0);
    io(1'b1, REG_RD_ADDR, {7'h0, SA | 25'h80});
    rdreg(REG_RD_DATA, 32'h00001234);
    rdreg(REG_RD_DATA, 32'h0000ffff);
    io(1'b1, REG_RD_ADDR, {7'h0, SA | 25'hff});
    rdreg(REG_RD_DATA, 32'h0000ffff);
    rdreg(REG_RD_DATA, {16'h0, FACTORY_FILL});
    io(1'b1, REG_RD_ADDR, 32'h00040000);
    io(1'b0, REG_RD_DATA, 32'h0);
    cmp1(rd[RD_ARRAY_BIT], 1'b1);
    prog(8'h80, 16'h0000);
    st(32'h40, 32'h40);
    prog(8'h00, 16'h0000);
    st(32'h40, 32'h40);
    prog(8'h82, 16'h0000);
    st(32'h40, 32'h0);
    io(1'b1, REG_LOCK_WORD, 32'h0000fffc);
    rdreg(REG_LOCK_WORD, 32'h0000fffc);
    prog(8'h81, 16'h5555);
    st(32'h40, 32'h40);
    cmd(25'h0, CMD_EXIT);
    sec(1'b0);
    acc <= 1'b0;
    deny(25'h030000, 1'b1);
    acc <= 1'b1;
    // each blocking pin alone must refuse entry
    for (int i = 0; i < 3; i++) begin
      blk <= 3'b001 << i;
      repeat (4) @(posedge i_core_clk);
      cmd(SA | 25'h555, CMD_SEC_ENTER);
      sec(1'b0);
    end
    blk <= 3'b000;
    do_reset();
    rdreg(REG_RANGE, 32'h0);
    range(25'h060040, 25'h070000);
    st(32'h3, 32'h2);
    range(25'h060000, 25'h070000);
    st(32'h3, 32'h2);
    results();
  end
endmodule : fsl_sector_lock_test

// [core/fsl_prot_chk.sv]
/*
  sector protection checker: decides whether the queried sector may be
  programmed or erased. assumes the user end holds all protection state.
*/
`timescale 1ns/1ps
module fsl_prot_chk
  import fsl_pkg::*;
(
  fsl_chk_if.checker_end chk
);
  logic [SEC_W-1:0] idx;
  logic key_hit;

  assign idx = sector_index(chk.addr);
  assign key_hit = chk.unl_valid && (sector_key(chk.addr) == chk.unl_key);
  // bounds compare whole 128 KB slots, so the small group goes as one
  assign chk.in_range = chk.range_valid && (idx >= chk.lo) && (idx <= chk.hi);
  assign chk.writable = !chk.acc_low && !chk.in_range && (!chk.prot_mode || key_hit);
endmodule : fsl_prot_chk

// [core/fsl_sector_lock.sv]
/*
  sector lock, range lock and secure region command logic behind an apb slave.
  assumes the host replays each flash bus write as cmd_addr then cmd_data
  writes; status pins arrive asynchronously and are synchronised here.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module fsl_sector_lock
  import fsl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_accelerate_protect_input,
  input wire logic i_embedded_busy,
  input wire logic i_op_suspended,
  input wire logic i_alternate_overlay_space_active,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_secure_mode
);
  typedef struct packed {
    fsl_seq_t seq;
    logic [ADDR_W-1:0] cmd_addr;
    logic [15:0] cmd_data;

    logic [SEC_W-1:0] pend_lo;
    logic pend_bad;
    logic [SEC_W-1:0] rng_lo;
    logic [SEC_W-1:0] rng_hi;
    logic rng_valid;
    logic rng_lockout;

    logic prot_mode;
    logic unl_valid;
    logic [KEY_W-1:0] unl_key;

    logic sec_mode;
    logic [SEC_W-1:0] sec_sector;

    logic [4:0] buf_cnt;
    logic [4:0] buf_idx;
    logic [BUF_DEPTH-1:0][7:0] buf_off;
    logic [BUF_DEPTH-1:0][15:0] buf_dat;
    logic [CUST_WORDS-1:0][15:0] cust_mem;
    logic [CUST_WORDS-1:0] cust_done;

    logic [15:0] lock_word;
    logic op_denied;
    logic prog_fail;
    logic [ADDR_W-1:0] rd_addr;

    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fsl_lock_st_t;

  fsl_lock_st_t s_reg;
  fsl_lock_st_t s_next;

  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] pins_q;
  logic acc_low;
  logic region_blocked;

  logic access;
  logic done;
  logic wr_done;
  logic rd_done;

  logic mapped;
  logic [15:0] cmd_d;
  logic [11:0] cmd_lo12;
  logic cmd_sel;
  logic [SEC_W-1:0] cmd_idx;

  logic in_overlay;
  logic [7:0] rd_off;
  logic [15:0] rd_word;
  logic commit_fail;
  logic [7:0] off;

  fsl_chk_if chk ();

  assign pins_raw[PIN_ACC] = i_accelerate_protect_input;
  assign pins_raw[PIN_BUSY] = i_embedded_busy;
  assign pins_raw[PIN_SUSP] = i_op_suspended;
  assign pins_raw[PIN_AOS] = i_alternate_overlay_space_active;

  fsl_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pins(pins_raw),
    .o_pins(pins_q)
  );

  fsl_prot_chk u_chk (
    .chk(chk.checker_end)
  );

  // pin low after reset reads as protected, the safe side
  assign acc_low = !pins_q[PIN_ACC];
  assign region_blocked = pins_q[PIN_BUSY] | pins_q[PIN_SUSP] | pins_q[PIN_AOS];

  assign chk.addr = s_reg.cmd_addr;
  assign chk.lo = s_reg.rng_lo;
  assign chk.hi = s_reg.rng_hi;
  assign chk.range_valid = s_reg.rng_valid;
  assign chk.prot_mode = s_reg.prot_mode;
  assign chk.unl_valid = s_reg.unl_valid;
  assign chk.unl_key = s_reg.unl_key;
  assign chk.acc_low = acc_low;

  // one wait state so read data and ready both leave flops
  assign access = i_psel && i_penable;
  assign done = access && s_reg.pready;
  assign wr_done = done && i_pwrite && !s_reg.pslverr;
  assign rd_done = done && !i_pwrite && !s_reg.pslverr;

  assign cmd_d = i_pwdata[15:0];
  assign cmd_lo12 = s_reg.cmd_addr[11:0];
  assign cmd_sel = s_reg.cmd_addr[LOCK_SEL_BIT];
  assign cmd_idx = sector_index(s_reg.cmd_addr);

  assign in_overlay = s_reg.sec_mode && (sector_index(s_reg.rd_addr) == s_reg.sec_sector);
  assign rd_off = s_reg.rd_addr[7:0];
  assign rd_word = rd_off[CUST_SEL_BIT] ? s_reg.cust_mem[rd_off[6:0]] : FACTORY_FILL;

  always_comb begin
    mapped = 1'b1;
    case (i_paddr)
      REG_CMD_ADDR, REG_CMD_DATA, REG_STATUS, REG_RANGE, REG_UNLOCK: mapped = 1'b1;
      REG_OP_CHECK, REG_RD_ADDR, REG_RD_DATA, REG_LOCK_WORD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // a buffer fails whole if any word is refused; nothing is half written
  always_comb begin
    commit_fail = acc_low || !s_reg.lock_word[CUST_BIT];
    off = 8'h00;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      off = s_reg.buf_off[i];
      if (5'(i) <= s_reg.buf_cnt) begin
        if (!off[CUST_SEL_BIT] || s_reg.cust_done[off[6:0]]) begin
          commit_fail = 1'b1;
        end
      end
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.pready = access && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (access && !s_reg.pready) begin
      s_next.pslverr = !mapped || (i_pwrite && i_pstrb != 4'hf);
      s_next.prdata = 32'h0000_0000;
      if (!i_pwrite) begin
        case (i_paddr)
          REG_CMD_ADDR: s_next.prdata = 32'(s_reg.cmd_addr);
          REG_CMD_DATA: s_next.prdata = {16'h0000, s_reg.cmd_data};
          REG_STATUS: begin
            s_next.prdata[ST_RANGE_VALID] = s_reg.rng_valid;
            s_next.prdata[ST_RANGE_LOCKOUT] = s_reg.rng_lockout;
            s_next.prdata[ST_SECURE_MODE] = s_reg.sec_mode;
            s_next.prdata[ST_PROT_MODE] = s_reg.prot_mode;
            s_next.prdata[ST_UNL_VALID] = s_reg.unl_valid;
            s_next.prdata[ST_OP_DENIED] = s_reg.op_denied;
            s_next.prdata[ST_PROG_FAIL] = s_reg.prog_fail;
            s_next.prdata[ST_ACC_LOW] = acc_low;
            s_next.prdata[ST_SEQ_BUSY] = (s_reg.seq != SEQ_IDLE);
          end
          REG_RANGE: begin
            s_next.prdata[SEC_W-1:0] = s_reg.rng_lo;
            s_next.prdata[RANGE_HI_LSB +: SEC_W] = s_reg.rng_hi;
          end
          REG_UNLOCK: s_next.prdata = 32'(s_reg.unl_key);
          REG_RD_ADDR: s_next.prdata = 32'(s_reg.rd_addr);
          REG_RD_DATA: begin
            s_next.prdata[15:0] = in_overlay ? rd_word : 16'h0000;
            s_next.prdata[RD_ARRAY_BIT] = !in_overlay;
          end
          REG_LOCK_WORD: s_next.prdata = {16'h0000, s_reg.lock_word};
          default: s_next.prdata = 32'h0000_0000;
        endcase
      end
    end

    // burst within the overlay wraps ffh to 00h
    if (rd_done && i_paddr == REG_RD_DATA && in_overlay) begin
      s_next.rd_addr[7:0] = s_reg.rd_addr[7:0] + 8'h01;
    end

    if (wr_done) begin
      case (i_paddr)
        REG_CMD_ADDR: s_next.cmd_addr = i_pwdata[ADDR_W-1:0];
        REG_RD_ADDR: s_next.rd_addr = i_pwdata[ADDR_W-1:0];
        REG_OP_CHECK: s_next.op_denied = !chk.writable;

        REG_LOCK_WORD: begin
          // bit 0 only ever clears; only reset sets it back
          if (!i_pwdata[CUST_BIT]) begin
            if (acc_low) begin
              s_next.prog_fail = 1'b1;
            end else begin
              s_next.lock_word[CUST_BIT] = 1'b0;
              s_next.prog_fail = 1'b0;
            end
          end
        end

        REG_CMD_DATA: begin
          s_next.cmd_data = cmd_d;
          case (s_reg.seq)
            SEQ_IDLE: begin
              if (cmd_d == CMD_EXIT) begin
                s_next.sec_mode = 1'b0;
              end else if (s_reg.sec_mode) begin
                if (cmd_d == CMD_PROG_SETUP && cmd_lo12 == CYC_ADDR_A) begin
                  s_next.seq = SEQ_PROG_COUNT;
                end
              end else if (cmd_d == CMD_SEC_ENTER && cmd_lo12 == CYC_ADDR_A) begin
                if (!region_blocked) begin
                  s_next.sec_mode = 1'b1;
                  s_next.sec_sector = cmd_idx;
                end
              end else if (cmd_d == CMD_LOCK_SETUP && cmd_lo12 == CYC_ADDR_A) begin
                s_next.seq = SEQ_SETUP1;
              end
            end

            SEQ_SETUP1: begin
              if (cmd_d == CMD_LOCK_SETUP && (cmd_lo12 == CYC_ADDR_A || cmd_lo12 == CYC_ADDR_B)) begin
                s_next.seq = SEQ_SETUP2;
              end else begin
                s_next.seq = SEQ_IDLE;
              end
            end

            SEQ_SETUP2: begin
              s_next.seq = SEQ_IDLE;
              if (cmd_d == CMD_LOCK_SETUP) begin
                s_next.prot_mode = 1'b1;
                if (cmd_sel && !chk.in_range) begin
                  s_next.unl_valid = 1'b1;
                  s_next.unl_key = sector_key(s_reg.cmd_addr);
                end else begin
                  s_next.unl_valid = 1'b0;
                end
              end else if (cmd_d == CMD_RANGE_LOAD) begin
                s_next.pend_lo = cmd_idx;
                s_next.pend_bad = cmd_sel;
                s_next.seq = SEQ_RANGE_HI;
              end
            end

            SEQ_RANGE_HI: begin
              s_next.seq = SEQ_IDLE;
              if (cmd_d == CMD_RANGE_LOAD && !s_reg.rng_lockout) begin
                if (s_reg.pend_bad || cmd_sel) begin
                  s_next.rng_lockout = 1'b1;
                end else if (s_reg.pend_lo <= cmd_idx) begin
                  s_next.rng_lo = s_reg.pend_lo;
                  s_next.rng_hi = cmd_idx;
                  s_next.rng_valid = 1'b1;
                  s_next.rng_lockout = 1'b1;
                  s_next.prot_mode = 1'b1;
                  s_next.unl_valid = 1'b0;
                end
              end
            end

            SEQ_PROG_COUNT: begin
              if (cmd_lo12 == CYC_ADDR_B && cmd_d <= BUF_MAX_CNT) begin
                s_next.buf_cnt = cmd_d[4:0];
                s_next.buf_idx = 5'h00;
                s_next.seq = SEQ_PROG_LOAD;
              end else begin
                s_next.seq = SEQ_IDLE;
              end
            end

            // 00f0h here is data, so any word can be stored
            SEQ_PROG_LOAD: begin
              s_next.buf_off[s_reg.buf_idx] = s_reg.cmd_addr[7:0];
              s_next.buf_dat[s_reg.buf_idx] = cmd_d;
              s_next.buf_idx = s_reg.buf_idx + 5'h01;
              if (s_reg.buf_idx == s_reg.buf_cnt) begin
                s_next.seq = SEQ_PROG_COMMIT;
              end
            end

            SEQ_PROG_COMMIT: begin
              s_next.seq = SEQ_IDLE;
              if (cmd_d == CMD_PROG_COMMIT) begin
                s_next.prog_fail = commit_fail;
                if (!commit_fail) begin
                  for (int i = 0; i < BUF_DEPTH; i++) begin
                    if (5'(i) <= s_reg.buf_cnt) begin
                      s_next.cust_mem[s_reg.buf_off[i][6:0]] = s_reg.buf_dat[i];
                      s_next.cust_done[s_reg.buf_off[i][6:0]] = 1'b1;
                    end
                  end
                end
              end else if (cmd_d == CMD_EXIT) begin
                s_next.sec_mode = 1'b0;
              end
            end

            default: s_next.seq = SEQ_IDLE;
          endcase
          // exit leaves secure mode from any step except a data word
          if (cmd_d == CMD_EXIT && s_reg.seq != SEQ_PROG_LOAD) begin
            s_next.sec_mode = 1'b0;
            s_next.seq = SEQ_IDLE;
          end
        end

        default: s_next.seq = s_reg.seq;
      endcase
    end
  end

  // range state has no other clear than this reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.seq <= SEQ_IDLE;
      s_reg.lock_word <= LOCK_WORD_RST;
      s_reg.cust_mem <= {CUST_WORDS{ERASED_WORD}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pready = s_reg.pready;
  assign o_prdata = s_reg.prdata;
  assign o_pslverr = s_reg.pslverr;
  assign o_secure_mode = s_reg.sec_mode;
endmodule : fsl_sector_lock

// [core/fsl_sync.sv]
/*
  three-flop synchroniser for the asynchronous status pins.
  assumes pins change slowly; a change counts once stages two and three agree.
*/
`timescale 1ns/1ps
module fsl_sync
  import fsl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [PIN_N-1:0] i_pins,
  output logic [PIN_N-1:0] o_pins
);
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] q;
  } fsl_sync_st_t;

  fsl_sync_st_t s_reg;
  fsl_sync_st_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = i_pins;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    // hold on disagreement, filters one-stage glitches
    s_next.q = (s_reg.s2 & s_reg.s3) | (s_reg.q & (s_reg.s2 ^ s_reg.s3));
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, q: SYNC_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pins = s_reg.q;
endmodule : fsl_sync

// [pkg/fsl_chk_if.sv]
/*
  carrier between the command block and the sector protection checker.
  assumes both ends share the core clock domain; no state inside.
*/
`timescale 1ns/1ps
interface fsl_chk_if;
  import fsl_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [SEC_W-1:0] lo;
  logic [SEC_W-1:0] hi;
  logic range_valid;
  logic prot_mode;
  logic unl_valid;
  logic [KEY_W-1:0] unl_key;
  logic acc_low;
  logic in_range;
  logic writable;
  modport checker_end(input addr, lo, hi, range_valid, prot_mode, unl_valid, unl_key, acc_low,
                      output in_range, writable);
  modport user_end(output addr, lo, hi, range_valid, prot_mode, unl_valid, unl_key, acc_low,
                   input in_range, writable);
endinterface : fsl_chk_if

// [pkg/fsl_pkg.sv]
/*
  shared constants, types and decode functions for the sector lock block.
  assumes a 25-bit word address, 128 KB sectors and one group of four small
  boot sectors at the bottom of the array.
*/
// What this block does
// - range lock: two 60h setups, two 61h bounds
// - third write low bound, fourth high bound
// - range sectors refuse program/erase until reset
// - small boot sectors protected as one group
// - equal bounds lock just that sector
// - bounds accepted only with select bit zero
// - low above high rejects the sequence
// - select bit one disables later range commands
// - one valid range lock per reset
// - range lock protects all; unlock singly outside
// - range overrides unlock, even earlier unlocks
// - accelerate low blocks all program and erase
// - lock word: customer bit0, factory bit1, rest one
// - customer flag zero refuses secure programming
// - factory flag always zero; customer starts one
// - secure words program once, lock once
// - protected secure program fails with status
// - entry 0088h at 555h picks overlaid sector
// - secure mode ends on 00f0h (not as a buffer data word) or reset
// - outside overlay reads array; burst wraps ffh
// - no secure entry while busy, suspended, overlaid
// - all unlocked at start; one unlocked after
// - select bit zero locks all, one unlocks
package fsl_pkg;
  localparam int ADDR_W = 25;
  localparam int SEC_W = 9;
  localparam int KEY_W = 11;
  localparam int SEC_LSB = 16;
  localparam int SMALL_LSB = 14;
  localparam int LOCK_SEL_BIT = 6;
  localparam logic [11:0] CYC_ADDR_A = 12'h555;
  localparam logic [11:0] CYC_ADDR_B = 12'h2aa;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_RANGE_LOAD = 16'h0061;
  localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [15:0] CMD_EXIT = 16'h00f0;
  localparam logic [15:0] CMD_PROG_SETUP = 16'h0025;
  localparam logic [15:0] CMD_PROG_COMMIT = 16'h0029;
  localparam int BUF_DEPTH = 32;
  localparam logic [15:0] BUF_MAX_CNT = 16'h001f;
  localparam int CUST_WORDS = 128;
  localparam int CUST_SEL_BIT = 7;
  localparam int CUST_BIT = 0;
  localparam int FACT_BIT = 1;
  localparam logic [15:0] LOCK_WORD_RST = 16'hfffd;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] FACTORY_FILL = 16'h0000; // arbitrary content
  localparam logic [7:0] REG_CMD_ADDR = 8'h00;
  localparam logic [7:0] REG_CMD_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RANGE = 8'h0c;
  localparam logic [7:0] REG_UNLOCK = 8'h10;
  localparam logic [7:0] REG_OP_CHECK = 8'h14;
  localparam logic [7:0] REG_RD_ADDR = 8'h18;
  localparam logic [7:0] REG_RD_DATA = 8'h1c;
  localparam logic [7:0] REG_LOCK_WORD = 8'h20;
  localparam int ST_RANGE_VALID = 0;
  localparam int ST_RANGE_LOCKOUT = 1;
  localparam int ST_SECURE_MODE = 2;
  localparam int ST_PROT_MODE = 3;
  localparam int ST_UNL_VALID = 4;
  localparam int ST_OP_DENIED = 5;
  localparam int ST_PROG_FAIL = 6;
  localparam int ST_ACC_LOW = 7;
  localparam int ST_SEQ_BUSY = 8;
  localparam int RD_ARRAY_BIT = 16;
  localparam int RANGE_HI_LSB = 16;
  localparam int PIN_N = 4;
  localparam int PIN_ACC = 0;
  localparam int PIN_BUSY = 1;
  localparam int PIN_SUSP = 2;
  localparam int PIN_AOS = 3;
  localparam logic [PIN_N-1:0] SYNC_RST = 4'h0;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_SETUP1, SEQ_SETUP2, SEQ_RANGE_HI,
    SEQ_PROG_COUNT, SEQ_PROG_LOAD, SEQ_PROG_COMMIT
  } fsl_seq_t;

  function automatic logic [SEC_W-1:0] sector_index(input logic [ADDR_W-1:0] addr);
    sector_index = addr[ADDR_W-1:SEC_LSB];
  endfunction : sector_index

  // small sectors get their own key so each may be unlocked alone
  function automatic logic [KEY_W-1:0] sector_key(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:SEC_LSB] == '0) begin
      sector_key = {{SEC_W{1'b0}}, addr[SEC_LSB-1:SMALL_LSB]};
    end else begin
      sector_key = {addr[ADDR_W-1:SEC_LSB], 2'b00};
    end
  endfunction : sector_key
endpackage : fsl_pkg
